/* File: logic/isr_pkg.sv */
// Package for the status reporting block: register offsets, bit positions,
// reset value and query select codes.
// Assumes an APB master with 32-bit data and one aligned word per register.
package isr_pkg;
  localparam logic [7:0] ISR_OFS_STB = 8'h00;
  localparam logic [7:0] ISR_OFS_SRE = 8'h04;
  localparam logic [7:0] ISR_OFS_SEV = 8'h08;
  localparam logic [7:0] ISR_OFS_SEN = 8'h0C;
  localparam logic [7:0] ISR_OFS_OCN = 8'h10;
  localparam logic [7:0] ISR_OFS_OEV = 8'h14;
  localparam logic [7:0] ISR_OFS_OEN = 8'h18;
  localparam logic [7:0] ISR_OFS_CMD = 8'h1C;
  localparam logic [7:0] ISR_OFS_QRY = 8'h20;
  localparam logic [7:0] ISR_OFS_RSP = 8'h24;
  localparam int ISR_BIT_OSB = 7;
  localparam int ISR_BIT_RQS = 6;
  localparam int ISR_BIT_ESB = 5;
  localparam int ISR_BIT_MAV = 4;
  localparam int ISR_CMD_CLS = 0;
  localparam int ISR_CMD_POLL = 1;
  localparam logic [7:0] ISR_RST_BYTE = 8'h00;
  localparam logic [3:0] ISR_Q_STB = 4'h1;
  localparam logic [3:0] ISR_Q_SRE = 4'h2;
  localparam logic [3:0] ISR_Q_SEV = 4'h3;
  localparam logic [3:0] ISR_Q_SEN = 4'h4;
  localparam logic [3:0] ISR_Q_OCN = 4'h5;
  localparam logic [3:0] ISR_Q_OEV = 4'h6;
  localparam logic [3:0] ISR_Q_OEN = 4'h7;
endpackage

/* File: logic/isr_status.sv */
// Status reporting block: event register sets, status byte, service
// request line and a single pending query response slot, behind APB.
// Assumes event and condition inputs are already synchronous to pclk.
//
// The address map and register access over APB are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none

// Contract
// - Response goes out only while addressed to talk.
// - A query alone never transmits; it only prepares a response.
// - Only the latest query before talk addressing is answered.
// - Condition registers are live, unlatched, read-only, never cleared.
// - Standard event set has no condition register; operation set has.
// - Event bits latch on events; repeats while set do nothing.
// - Event bits stay set until clearing query or clear-status.
// - Summary is OR of event AND enable per set.
// - Enable registers read/write; other status registers read-only.
// - Status byte is read-only and follows the summaries directly.
// - Master summary is set by any enabled summary; drives service request.
// - Status byte query reports master summary state.
// - Query value is the 8-bit binary-weighted register value.
// - Standard event register query returns contents then clears it.
// - Writing 0 to an enable register clears all its bits.
// - Clear-status clears all event registers and thus summaries.
// - Status byte is never cleared directly, only via its sources.
// - Service request asserts on a rising master summary.
// - Serial poll releases service request; master summary stays set.
// - Status byte bits: operation 7, master 6, standard 5, message 4.
module isr_status (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] std_evt,
  input wire logic [7:0] op_evt,
  input wire logic [7:0] op_cond,
  input wire logic talk_addr,
  input wire logic rsp_take,
  output logic [7:0] rsp_data,
  output logic rsp_valid,
  output logic srq
);
  logic [7:0] sev_r, sen_r, oev_r, oen_r, sre_r, rsp_r;
  logic mav_r, rqs_r, mss_d_r;
  logic [7:0] sev_nxt, oev_nxt, rsp_nxt, stb;
  logic wr, rd, a_stb, a_sre, a_sev, a_sen, a_ocn, a_oev, a_oen;
  logic a_cmd, a_qry, a_rsp, ok, cls, poll, qry_wr, sev_qry, oev_qry;
  logic std_sum, op_sum, mss, mss_rise;
  logic [3:0] qsel;
  logic [7:0] wbyte;

  assign wr = psel & penable & pwrite & clk_en;
  assign rd = psel & penable & ~pwrite & clk_en;
  assign a_stb = paddr == isr_pkg::ISR_OFS_STB;
  assign a_sre = paddr == isr_pkg::ISR_OFS_SRE;
  assign a_sev = paddr == isr_pkg::ISR_OFS_SEV;
  assign a_sen = paddr == isr_pkg::ISR_OFS_SEN;
  assign a_ocn = paddr == isr_pkg::ISR_OFS_OCN;
  assign a_oev = paddr == isr_pkg::ISR_OFS_OEV;
  assign a_oen = paddr == isr_pkg::ISR_OFS_OEN;
  assign a_cmd = paddr == isr_pkg::ISR_OFS_CMD;
  assign a_qry = paddr == isr_pkg::ISR_OFS_QRY;
  assign a_rsp = paddr == isr_pkg::ISR_OFS_RSP;
  assign ok = a_stb | a_sre | a_sev | a_sen | a_ocn | a_oev | a_oen
    | a_cmd | a_qry | a_rsp;
  assign pready = 1'b1;
  // Writes to read-only registers are flagged as errors and store nothing.
  assign pslverr = psel & penable & (~ok | (pwrite & (a_stb | a_sev | a_ocn
    | a_oev | a_rsp)) | (~pwrite & (a_cmd | a_qry)));

  assign cls = wr & a_cmd & pwdata[isr_pkg::ISR_CMD_CLS];
  assign poll = wr & a_cmd & pwdata[isr_pkg::ISR_CMD_POLL];
  assign qry_wr = wr & a_qry;
  assign qsel = pwdata[3:0];
  assign wbyte = pwdata[7:0];
  // A direct APB read of the standard event register also reads and clears.
  assign sev_qry = (qry_wr & (qsel == isr_pkg::ISR_Q_SEV))
    | (rd & a_sev);
  assign oev_qry = (qry_wr & (qsel == isr_pkg::ISR_Q_OEV)) | (rd & a_oev);

  // Set wins over clear so an event in the clearing cycle is kept.
  assign sev_nxt = ((sev_qry | cls) ? 8'h00 : sev_r) | std_evt;
  assign oev_nxt = ((oev_qry | cls) ? 8'h00 : oev_r) | op_evt;

  assign std_sum = |(sev_r & sen_r);
  assign op_sum = |(oev_r & oen_r);
  // Only sources feed the status byte; it has no storage to clear.
  assign mss = |({op_sum, std_sum, mav_r} & {sre_r[isr_pkg::ISR_BIT_OSB],
    sre_r[isr_pkg::ISR_BIT_ESB], sre_r[isr_pkg::ISR_BIT_MAV]});
  assign mss_rise = mss & ~mss_d_r;
  always_comb begin
    stb = isr_pkg::ISR_RST_BYTE;
    stb[isr_pkg::ISR_BIT_OSB] = op_sum;
    stb[isr_pkg::ISR_BIT_RQS] = mss;
    stb[isr_pkg::ISR_BIT_ESB] = std_sum;
    stb[isr_pkg::ISR_BIT_MAV] = mav_r;
  end

  // Value kept in binary-weighted form; rsp_data carries the same byte unconverted.
  always_comb begin
    unique case (qsel)
      isr_pkg::ISR_Q_STB: rsp_nxt = stb;
      isr_pkg::ISR_Q_SRE: rsp_nxt = sre_r;
      isr_pkg::ISR_Q_SEV: rsp_nxt = sev_r;
      isr_pkg::ISR_Q_SEN: rsp_nxt = sen_r;
      isr_pkg::ISR_Q_OCN: rsp_nxt = op_cond;
      isr_pkg::ISR_Q_OEV: rsp_nxt = oev_r;
      isr_pkg::ISR_Q_OEN: rsp_nxt = oen_r;
      default: rsp_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sev_r <= isr_pkg::ISR_RST_BYTE;
      oev_r <= isr_pkg::ISR_RST_BYTE;
    end else if (clk_en) begin
      sev_r <= sev_nxt;
      oev_r <= oev_nxt;
    end
  end

  // Enable writes take the low byte; writing zero clears every bit.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sen_r <= isr_pkg::ISR_RST_BYTE;
      oen_r <= isr_pkg::ISR_RST_BYTE;
      sre_r <= isr_pkg::ISR_RST_BYTE;
    end else begin
      if (wr & a_sen & pstrb[0]) sen_r <= pwdata[7:0];
      if (wr & a_oen & pstrb[0]) oen_r <= pwdata[7:0];
      if (wr & a_sre & pstrb[0]) sre_r <= pwdata[7:0];
    end
  end

  // One response slot: a newer query overwrites an older pending one.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rsp_r <= isr_pkg::ISR_RST_BYTE;
      mav_r <= 1'b0;
    end else if (clk_en) begin
      if (qry_wr) begin
        rsp_r <= rsp_nxt;
        mav_r <= 1'b1;
      end else if ((rsp_take & talk_addr) | cls) begin
        mav_r <= 1'b0;
      end
    end
  end

  // A new rising edge of the master summary beats a poll in the same cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rqs_r <= 1'b0;
      mss_d_r <= 1'b0;
    end else if (clk_en) begin
      mss_d_r <= mss;
      if (mss_rise) rqs_r <= 1'b1;
      else if (poll | ~mss) rqs_r <= 1'b0;
    end
  end

  assign srq = rqs_r;
  assign rsp_valid = mav_r & talk_addr;
  assign rsp_data = rsp_r;

  always_comb begin
    prdata = 32'h0000_0000;
    if (rd) begin
      if (a_stb) prdata[7:0] = stb;
      if (a_sre) prdata[7:0] = sre_r;
      if (a_sev) prdata[7:0] = sev_r;
      if (a_sen) prdata[7:0] = sen_r;
      if (a_ocn) prdata[7:0] = op_cond;
      if (a_oev) prdata[7:0] = oev_r;
      if (a_oen) prdata[7:0] = oen_r;
      if (a_rsp) prdata[7:0] = rsp_r;
    end
  end

  a_resp_talk: assert property (@(posedge pclk) disable iff (!presetn)
    rsp_valid |-> talk_addr) else $error("response without talk address");
  a_query_latest: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && qry_wr) |=> (rsp_data == $past(rsp_nxt)))
    else $error("response not from latest query");
  a_event_latch: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && std_evt[0]) |=> sev_r[0]) else $error("event not latched");
  a_event_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && sev_r[1] && !sev_qry && !cls) |=> sev_r[1])
    else $error("event bit lost");
  a_summary_or: assert property (@(posedge pclk) disable iff (!presetn)
    stb[isr_pkg::ISR_BIT_ESB] == |(sev_r & sen_r))
    else $error("summary mismatch");
  a_esr_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && sev_qry && std_evt == 8'h00) |=> sev_r == 8'h00)
    else $error("event query did not clear");
  a_cls_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && cls && std_evt == 8'h00 && op_evt == 8'h00) |=>
    (stb[isr_pkg::ISR_BIT_ESB] == 1'b0 && stb[isr_pkg::ISR_BIT_OSB] == 1'b0))
    else $error("clear status left summary");
  a_srq_rise: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && $rose(mss)) |=> srq) else $error("no service request");
  a_poll_keep: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && poll && !mss_rise && mss) |=> (!srq && $past(mss) == 1'b1))
    else $error("poll did not release request");

  // The request latch follows a rising summary one enabled cycle later.
  sequence s_mss_up;
    clk_en && mss && !mss_d_r;
  endsequence

  sequence s_srq_up;
    ##1 srq;
  endsequence

  // A poll while nothing can drop the summary in the same cycle.
  sequence s_poll_hold;
    clk_en && poll && mss && mss_d_r && !cls && !sev_qry && !oev_qry
      && !(rsp_take && talk_addr);
  endsequence

  a_srq_seq: assert property (@(posedge pclk) disable iff (!presetn)
    s_mss_up |-> s_srq_up)
    else $error("request latch missed rising summary");

  // A poll drops the request but leaves the master summary standing.
  a_poll_mss: assert property (@(posedge pclk) disable iff (!presetn)
    s_poll_hold |=> (!srq && stb[isr_pkg::ISR_BIT_RQS]))
    else $error("poll cleared master summary");

  // Reset leaves no pending request, response or summary behind.
  a_reset_quiet: assert property (@(posedge pclk)
    !presetn |-> (!srq && !rsp_valid && stb == isr_pkg::ISR_RST_BYTE))
    else $error("state not clear in reset");

  a_cond_live: assert property (@(posedge pclk) disable iff (!presetn)
    (rd && a_ocn) |-> (prdata[7:0] == op_cond))
    else $error("condition read not live");

  a_ro_reject: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && pwrite && (a_stb || a_sev || a_ocn || a_oev))
      |-> pslverr)
    else $error("read-only write not refused");

  a_ro_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && wr && a_sev && std_evt == 8'h00) |=>
      (sev_r == $past(sev_r)))
    else $error("write changed event register");

  a_enable_write: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && a_sen && pstrb[0]) |=> (sen_r == $past(wbyte)))
    else $error("enable write not stored");

  a_enable_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && a_oen && pstrb[0] && wbyte == 8'h00) |=> (oen_r == 8'h00))
    else $error("zero write left enable bits");

  a_stb_follow: assert property (@(posedge pclk) disable iff (!presetn)
    (stb[isr_pkg::ISR_BIT_OSB] == |(oev_r & oen_r))
      && (stb[isr_pkg::ISR_BIT_MAV] == mav_r))
    else $error("status byte not following sources");

  a_mss_or: assert property (@(posedge pclk) disable iff (!presetn)
    stb[isr_pkg::ISR_BIT_RQS] ==
      ((stb[7] & sre_r[7]) | (stb[5] & sre_r[5]) | (stb[4] & sre_r[4])))
    else $error("master summary not enabled OR");

  a_query_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && qry_wr && !talk_addr) |=> (mav_r && !rsp_valid))
    else $error("query alone started a response");

  a_take_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && rsp_take && talk_addr && !qry_wr) |=> !mav_r)
    else $error("taken response still pending");

  // Queried values come back unscaled; the bit weights are the byte's own.
  a_rsp_value: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && qry_wr && qsel == isr_pkg::ISR_Q_SRE) |=>
      (rsp_data == $past(sre_r)))
    else $error("query value not register value");

  a_esr_value: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && qry_wr && qsel == isr_pkg::ISR_Q_SEV) |=>
      (rsp_data == $past(sev_r)))
    else $error("event query lost contents");

  a_cls_mav: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && cls && !qry_wr) |=> !mav_r)
    else $error("clear status kept response");

  a_stb_ro: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && pwrite && a_stb) |-> pslverr)
    else $error("status byte write not refused");

  // Serial poll and clear-status share one command word; both may be set.
  a_cls_poll: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && cls && poll && std_evt == 8'h00 && op_evt == 8'h00) |=>
      (!stb[isr_pkg::ISR_BIT_ESB] && !stb[isr_pkg::ISR_BIT_OSB]))
    else $error("combined command left summary");
endmodule // isr_status

`default_nettype wire

/* File: verif/isr_host.sv */
// Bus controller model: addresses the block to talk and takes one byte.
// Assumes fetch is called by the bench from the block's clock domain.
`timescale 1ns/1ns
`default_nettype none
module isr_host (
  input wire logic pclk,
  input wire logic [7:0] rsp_data,
  input wire logic rsp_valid,
  output logic talk_addr,
  output logic rsp_take
);
  initial begin
    talk_addr = 1'h0;
    rsp_take = 1'h0;
  end
  // A nonzero lag models a slow listener that keeps the block waiting.
  task automatic fetch(output logic [7:0] v, input int lag);
    int n;
    @(posedge pclk);
    talk_addr <= 1'h1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (rsp_valid !== 1'h1 && n < 20);
    repeat (lag) @(posedge pclk);
    v = (rsp_valid === 1'h1) ? rsp_data : 8'hxx;
    rsp_take <= 1'h1;
    @(posedge pclk);
    rsp_take <= 1'h0;
    talk_addr <= 1'h0;
  endtask
endmodule // isr_host
`default_nettype wire

/* File: verif/isr_status_tb_top.sv */
// Self-checking bench for the status block over APB with a host model.
// Assumes the block answers an APB access within a few cycles.
`timescale 1ns/1ns
`default_nettype none
module isr_status_tb_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic talk_addr, rsp_take, rsp_valid, srq;
  logic [7:0] paddr, std_evt, op_evt, op_cond, rsp_data, v;
  logic [31:0] pwdata, prdata, r;
  int errors, check_count;
  isr_status u_dut (.pclk(pclk), .presetn(presetn), .clk_en(1'h1),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .std_evt(std_evt), .op_evt(op_evt),
    .op_cond(op_cond), .talk_addr(talk_addr), .rsp_take(rsp_take),
    .rsp_data(rsp_data), .rsp_valid(rsp_valid), .srq(srq));
  isr_host u_host (.pclk(pclk), .rsp_data(rsp_data),
    .rsp_valid(rsp_valid), .talk_addr(talk_addr), .rsp_take(rsp_take));
  task automatic final_report();
    if (errors == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] s, x);
    check_count++;
    if (s !== x) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, x, s);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    r = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    if (pready !== 1'h1) begin
      errors++;
      final_report();
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x,
                    input string nm);
    apb(1'h0, a, 32'h0000_0000);
    chk(nm, r, x);
  endtask
  // Two falling edges let the registered service request settle.
  task automatic sq(input logic x);
    repeat (2) @(negedge pclk);
    chk("srq", {31'h0000_0000, srq}, {31'h0000_0000, x});
  endtask
  initial begin
    pclk = 1'h0;
    forever #10 pclk = ~pclk;
  end
  initial begin
    presetn = 1'h0;
    {psel, penable, pwrite} = 3'h0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    {std_evt, op_evt, op_cond} = 24'h00_0000;
    errors = 0;
    check_count = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'h1;
    rd(isr_pkg::ISR_OFS_STB, 32'h0000_0000, "stb");
    rd(isr_pkg::ISR_OFS_SRE, 32'h0000_0000, "sre");
    apb(1'h1, isr_pkg::ISR_OFS_SEN, 32'h0000_0020);
    rd(isr_pkg::ISR_OFS_SEN, 32'h0000_0020, "sen");
    std_evt <= 8'h21;
    @(posedge pclk);
    std_evt <= 8'h01;
    @(posedge pclk);
    std_evt <= 8'h00;
    rd(isr_pkg::ISR_OFS_STB, 32'h0000_0020, "esb");
    apb(1'h1, isr_pkg::ISR_OFS_SRE, 32'h0000_0020);
    sq(1'h1);
    rd(isr_pkg::ISR_OFS_STB, 32'h0000_0060, "mss");
    apb(1'h1, isr_pkg::ISR_OFS_CMD, 32'h0000_0002);
    sq(1'h0);
    rd(isr_pkg::ISR_OFS_STB, 32'h0000_0060, "mss");
    rd(isr_pkg::ISR_OFS_SEV, 32'h0000_0021, "sev");
    rd(isr_pkg::ISR_OFS_SEV, 32'h0000_0000, "sev");
    rd(isr_pkg::ISR_OFS_STB, 32'h0000_0000, "stb");
    op_cond <= 8'ha5;
    rd(isr_pkg::ISR_OFS_OCN, 32'h0000_00a5, "ocn");
    apb(1'h1, isr_pkg::ISR_OFS_OCN, 32'h0000_0000);
    chk("ro", {31'h0000_0000, e}, 32'h0000_0001);
    apb(1'h1, isr_pkg::ISR_OFS_OEN, 32'h0000_00ff);
    op_evt <= 8'h81;
    rd(isr_pkg::ISR_OFS_STB, 32'h0000_0080, "osb");
    op_evt <= 8'h00;
    apb(1'h1, isr_pkg::ISR_OFS_CMD, 32'h0000_0001);
    rd(isr_pkg::ISR_OFS_OEV, 32'h0000_0000, "cls");
    apb(1'h1, isr_pkg::ISR_OFS_SEN, 32'h0000_0000);
    rd(isr_pkg::ISR_OFS_SEN, 32'h0000_0000, "sen");
    apb(1'h1, isr_pkg::ISR_OFS_QRY, 32'h0000_0002);
    apb(1'h1, isr_pkg::ISR_OFS_QRY, 32'h0000_0007);
    chk("hold", {31'h0000_0000, rsp_valid}, 32'h0000_0000);
    rd(isr_pkg::ISR_OFS_STB, 32'h0000_0010, "mav");
    u_host.fetch(v, 3);
    chk("rsp", {24'h00_0000, v}, 32'h0000_00ff);
    final_report();
  end
endmodule // isr_status_tb_top
`default_nettype wire
